/* File: hdl/rgbp_consts.svh */
// Offsets, field positions, reset values and timing counts of the colour and proximity sensor.
`ifndef RGBP_CONSTS_SVH
`define RGBP_CONSTS_SVH

`define RGBP_CLK_MHZ        10
`define RGBP_STEP_US        2400
`define RGBP_PULSE_PER_US   14
`define RGBP_PULSE_ON_NS    6300
`define RGBP_WAIT_LONG_MUL  4'hC

`define RGBP_R_ENABLE   5'h00
`define RGBP_R_ITIME    5'h01
`define RGBP_R_WTIME    5'h02
`define RGBP_R_CONFIG   5'h03
`define RGBP_R_COL_LO   5'h04
`define RGBP_R_COL_HI   5'h05
`define RGBP_R_PRX_LO   5'h06
`define RGBP_R_PRX_HI   5'h07
`define RGBP_R_PERSIST  5'h08
`define RGBP_R_PULSES   5'h09
`define RGBP_R_DRIVE    5'h0A
`define RGBP_R_STATUS   5'h0B
`define RGBP_R_MASK     5'h0C
`define RGBP_R_DATA0    5'h10
`define RGBP_R_PRX_DATA 5'h14

`define RGBP_EN_PON     0
`define RGBP_EN_COL     1
`define RGBP_EN_PRX     2
`define RGBP_EN_WAIT    3
`define RGBP_CFG_WLONG  0
`define RGBP_ST_CVALID  0
`define RGBP_ST_PVALID  1
`define RGBP_ST_CINT    4
`define RGBP_ST_PINT    5

`define RGBP_RST_ITIME  8'hFF
`define RGBP_RST_WTIME  8'hFF
`define RGBP_RST_HI     16'hFFFF
`define RGBP_RST_PULSES 8'h01

`endif

/* File: hdl/rgbp_pkg.sv */
// Types of the colour and proximity sensor control block.
package rgbp_pkg;

    typedef enum logic [3:0] {
        ST_SLEEP  = 4'h1,
        ST_PROX   = 4'h2,
        ST_COLOUR = 4'h4,
        ST_WAIT   = 4'h8
    } rgbp_fsm_t;

    typedef enum logic [6:0] {
        I2_IDLE  = 7'h01,
        I2_ADDR  = 7'h02,
        I2_ACK_A = 7'h04,
        I2_WR    = 7'h08,
        I2_ACK_W = 7'h10,
        I2_RD    = 7'h20,
        I2_ACK_R = 7'h40
    } rgbp_i2c_t;

    // Index 0 clear, 1 red, 2 green, 3 blue.
    typedef logic [3:0][15:0] rgbp_chan_t;
    typedef logic [3:0][9:0]  rgbp_samp_t;

    typedef struct packed {
        rgbp_fsm_t   fsm;
        logic [19:0] stepc;
        logic [7:0]  nstep;
        logic [3:0]  sub;
        logic [7:0]  tick;
        logic [7:0]  pcnt;
        rgbp_chan_t  acc;
        logic [15:0] pacc;
        rgbp_chan_t  cdata;
        logic [15:0] pdata;
        logic [7:0]  enable;
        logic [7:0]  itime;
        logic [7:0]  wtime;
        logic [7:0]  cfg;
        logic [15:0] col_lo;
        logic [15:0] col_hi;
        logic [15:0] prx_lo;
        logic [15:0] prx_hi;
        logic [7:0]  pers;
        logic [7:0]  pulses;
        logic [1:0]  drive;
        logic [7:0]  status;
        logic [7:0]  mask;
        logic [3:0]  pcol;
        logic [3:0]  pprx;
        logic [15:0] rdata;
        logic [2:0]  scl_s;
        logic [2:0]  sda_s;
        rgbp_i2c_t   i2s;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic [7:0]  tx;
        logic [7:0]  ptr;
        logic [7:0]  wlo;
        logic [7:0]  hish;
        logic        rw;
        logic        first;
        logic        nack;
        logic        sda_oe;
    } rgbp_state_t;

endpackage

/* File: hdl/rgbp_top.sv */
// Colour and proximity sensor control: sequencer, thresholds, LED pulses, I2C target, registers.
// Contract
// - Four channel accumulators integrate together and saturate at 16 bits.
// - Results move to the readable data registers only when a cycle ends, and an I2C read of the high byte comes from a copy taken with the low byte.
// - An enabled threshold event raises a level interrupt that stays until software clears it.
// - A result below the lower limit or above the upper limit is a threshold event.
// - The interrupt is raised only after the programmed number of consecutive out-of-range results.
// - Colour and proximity keep their own limits and persistence and are judged apart.
// - Software picks one of four LED sink levels: 100, 50, 25 or 12.5 mA.
// - Each proximity measurement emits the programmed number of LED pulses, one to 255.
// - LED pulses repeat with a period of 14 us.
// - The interrupt pin is open drain and pulled low while the interrupt is asserted.
// - The I2C target works with bus clocks up to 400 kHz; the host model clocks at 1.25 MHz, above that rate.
// - A wait timer of 2.4 ms steps, twelve times longer in long mode, separates measurements.
// - The sequencer rests in a low-power state while asleep or waiting.
`timescale 1ns/1ps
`default_nettype none
`include "rgbp_consts.svh"

module rgbp_top #(
    parameter int         STEP_CYC = `RGBP_STEP_US * `RGBP_CLK_MHZ,
    // Arbitrary target address; set per ordered variant.
    parameter logic [6:0] I2C_ADDR = 7'h5A
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [4:0]        addr,
    input  wire logic [15:0]       wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic [15:0]            rdata,
    input  wire rgbp_pkg::rgbp_samp_t colour_channels,
    input  wire logic [9:0]        prox_sample,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    output logic                   int_out,
    output logic                   int_oe,
    output logic                   ir_led_sink_out,
    output logic [1:0]             led_drive_sel,
    output logic                   low_power
);
    localparam logic [19:0] STEP_LAST = 20'(STEP_CYC - 1);
    localparam logic [7:0]  PER_LAST  = 8'(`RGBP_PULSE_PER_US * `RGBP_CLK_MHZ - 1);
    localparam logic [7:0]  ON_CYC    = 8'(`RGBP_PULSE_ON_NS * `RGBP_CLK_MHZ / 1000);

    rgbp_pkg::rgbp_state_t st;
    rgbp_pkg::rgbp_state_t next_st;
    rgbp_pkg::rgbp_chan_t  col_sum;

    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [9:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {7'h00, b};
        return s[16] ? 16'hFFFF : s[15:0];
    endfunction

    function automatic logic [15:0] rd_reg(input rgbp_pkg::rgbp_state_t s, input logic [4:0] i);
        logic [15:0] v;
        v = 16'h0000;
        case (i)
            `RGBP_R_ENABLE:   v = {8'h00, s.enable};
            `RGBP_R_ITIME:    v = {8'h00, s.itime};
            `RGBP_R_WTIME:    v = {8'h00, s.wtime};
            `RGBP_R_CONFIG:   v = {8'h00, s.cfg};
            `RGBP_R_COL_LO:   v = s.col_lo;
            `RGBP_R_COL_HI:   v = s.col_hi;
            `RGBP_R_PRX_LO:   v = s.prx_lo;
            `RGBP_R_PRX_HI:   v = s.prx_hi;
            `RGBP_R_PERSIST:  v = {8'h00, s.pers};
            `RGBP_R_PULSES:   v = {8'h00, s.pulses};
            `RGBP_R_DRIVE:    v = {14'h0000, s.drive};
            `RGBP_R_STATUS:   v = {8'h00, s.status};
            `RGBP_R_MASK:     v = {8'h00, s.mask};
            `RGBP_R_PRX_DATA: v = s.pdata;
            default: begin
                if (i[4:2] == 3'h4) begin
                    v = s.cdata[i[1:0]];
                end
            end
        endcase
        return v;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            assign col_sum[gi] = sat_add(st.acc[gi], colour_channels[gi]);
        end
    endgenerate

    always_comb begin
        logic        rise;
        logic        fall;
        logic        i2c_wr;
        logic        load;
        logic        wen;
        logic [4:0]  widx;
        logic [15:0] wval;
        logic [15:0] rv;
        logic [15:0] psum;
        logic [3:0]  npc;
        logic        cout;
        logic        pout;
        rise   = 1'b0;
        fall   = 1'b0;
        i2c_wr = 1'b0;
        load   = 1'b0;
        wen    = 1'b0;
        widx   = 5'h00;
        wval   = 16'h0000;
        rv     = 16'h0000;
        psum   = sat_add(st.pacc, prox_sample);
        npc    = 4'h0;
        cout   = 1'b0;
        pout   = 1'b0;
        next_st = st;

        // I2C target; only the second synchroniser stage and later are read.
        next_st.scl_s = {st.scl_s[1:0], scl_in};
        next_st.sda_s = {st.sda_s[1:0], sda_in};
        rise = st.scl_s[1] & ~st.scl_s[2];
        fall = ~st.scl_s[1] & st.scl_s[2];
        if (st.scl_s[1] & st.scl_s[2] & (st.sda_s[1] ^ st.sda_s[2])) begin
            next_st.sda_oe = 1'b0;
            next_st.cnt    = 4'h0;
            next_st.first  = 1'b1;
            next_st.i2s    = st.sda_s[1] ? rgbp_pkg::I2_IDLE : rgbp_pkg::I2_ADDR;
        end else begin
            unique case (st.i2s)
                rgbp_pkg::I2_IDLE: begin
                end
                rgbp_pkg::I2_ADDR, rgbp_pkg::I2_WR: begin
                    if (rise) begin
                        next_st.sh  = {st.sh[6:0], st.sda_s[1]};
                        next_st.cnt = st.cnt + 4'h1;
                    end else if (fall && st.cnt == 4'h8) begin
                        next_st.cnt = 4'h0;
                        if (st.i2s == rgbp_pkg::I2_ADDR) begin
                            if (st.sh[7:1] == I2C_ADDR) begin
                                next_st.rw     = st.sh[0];
                                next_st.i2s    = rgbp_pkg::I2_ACK_A;
                                next_st.sda_oe = 1'b1;
                            end else begin
                                next_st.i2s = rgbp_pkg::I2_IDLE;
                            end
                        end else begin
                            next_st.i2s    = rgbp_pkg::I2_ACK_W;
                            next_st.sda_oe = 1'b1;
                            next_st.first  = 1'b0;
                            if (st.first) begin
                                next_st.ptr = st.sh;
                            end else begin
                                next_st.ptr = st.ptr + 8'h01;
                                next_st.wlo = st.sh;
                                i2c_wr      = st.ptr[0];
                            end
                        end
                    end
                end
                rgbp_pkg::I2_ACK_A, rgbp_pkg::I2_ACK_W: begin
                    if (fall) begin
                        next_st.sda_oe = 1'b0;
                        next_st.i2s    = rgbp_pkg::I2_WR;
                        load           = st.rw && st.i2s == rgbp_pkg::I2_ACK_A;
                    end
                end
                rgbp_pkg::I2_RD: begin
                    if (fall) begin
                        next_st.cnt = st.cnt + 4'h1;
                        next_st.tx  = {st.tx[6:0], 1'b0};
                        next_st.sda_oe = ~st.tx[6];
                        if (st.cnt == 4'h8) begin
                            next_st.sda_oe = 1'b0;
                            next_st.i2s    = rgbp_pkg::I2_ACK_R;
                        end
                    end
                end
                rgbp_pkg::I2_ACK_R: begin
                    if (rise) begin
                        next_st.nack = st.sda_s[1];
                    end else if (fall) begin
                        next_st.i2s = rgbp_pkg::I2_IDLE;
                        load        = ~st.nack;
                    end
                end
            endcase
        end
        if (load) begin
            rv          = rd_reg(st, st.ptr[5:1]);
            next_st.tx  = st.ptr[0] ? st.hish : rv[7:0];
            next_st.hish = st.ptr[0] ? st.hish : rv[15:8];
            next_st.sda_oe = st.ptr[0] ? ~st.hish[7] : ~rv[7];
            next_st.ptr = st.ptr + 8'h01;
            next_st.cnt = 4'h1;
            next_st.i2s = rgbp_pkg::I2_RD;
        end

        // Register port; a bus write wins over an I2C commit in the same cycle.
        if (rd_stb) begin
            next_st.rdata = rd_reg(st, addr);
        end
        if (wr_stb) begin
            wen  = 1'b1;
            widx = addr;
            wval = wdata;
        end else if (i2c_wr) begin
            wen  = 1'b1;
            widx = st.ptr[5:1];
            wval = {st.sh, st.wlo};
        end
        if (wen) begin
            case (widx)
                `RGBP_R_ENABLE:  next_st.enable = wval[7:0];
                `RGBP_R_ITIME:   next_st.itime  = wval[7:0];
                `RGBP_R_WTIME:   next_st.wtime  = wval[7:0];
                `RGBP_R_CONFIG:  next_st.cfg    = wval[7:0];
                `RGBP_R_COL_LO:  next_st.col_lo = wval;
                `RGBP_R_COL_HI:  next_st.col_hi = wval;
                `RGBP_R_PRX_LO:  next_st.prx_lo = wval;
                `RGBP_R_PRX_HI:  next_st.prx_hi = wval;
                `RGBP_R_PERSIST: next_st.pers   = wval[7:0];
                `RGBP_R_PULSES:  next_st.pulses = wval[7:0];
                `RGBP_R_DRIVE:   next_st.drive  = wval[1:0];
                `RGBP_R_STATUS:  next_st.status = st.status & ~wval[7:0];
                `RGBP_R_MASK:    next_st.mask   = wval[7:0];
                default: begin
                end
            endcase
        end

        // Measurement sequencer; status sets come after the clear so that they win.
        unique case (st.fsm)
            rgbp_pkg::ST_SLEEP: begin
                next_st.fsm = rgbp_pkg::ST_PROX;
            end
            rgbp_pkg::ST_PROX: begin
                if (!st.enable[`RGBP_EN_PRX] || st.pulses == 8'h00) begin
                    next_st.fsm = rgbp_pkg::ST_COLOUR;
                end else begin
                    next_st.tick = st.tick + 8'h01;
                    if (st.tick == PER_LAST) begin
                        next_st.tick = 8'h00;
                        next_st.pacc = psum;
                        next_st.pcnt = st.pcnt + 8'h01;
                        if (st.pcnt == st.pulses - 8'h01) begin
                            next_st.pdata = psum;
                            next_st.fsm   = rgbp_pkg::ST_COLOUR;
                            pout = psum < st.prx_lo || psum > st.prx_hi;
                            npc  = pout ? st.pprx + {3'h0, st.pprx != 4'hF} : 4'h0;
                            next_st.pprx = npc;
                            next_st.status[`RGBP_ST_PVALID] = 1'b1;
                            if (pout && npc >= st.pers[7:4]) begin
                                next_st.status[`RGBP_ST_PINT] = 1'b1;
                            end
                        end
                    end
                end
            end
            rgbp_pkg::ST_COLOUR: begin
                if (!st.enable[`RGBP_EN_COL]) begin
                    next_st.fsm = rgbp_pkg::ST_WAIT;
                end else begin
                    next_st.stepc = st.stepc + 20'h00001;
                    if (st.stepc == STEP_LAST) begin
                        next_st.stepc = 20'h00000;
                        next_st.acc   = col_sum;
                        next_st.nstep = st.nstep + 8'h01;
                        if (st.nstep == 8'hFF) begin
                            next_st.cdata = col_sum;
                            next_st.fsm   = rgbp_pkg::ST_WAIT;
                            cout = col_sum[0] < st.col_lo || col_sum[0] > st.col_hi;
                            npc  = cout ? st.pcol + {3'h0, st.pcol != 4'hF} : 4'h0;
                            next_st.pcol = npc;
                            next_st.status[`RGBP_ST_CVALID] = 1'b1;
                            if (cout && npc >= st.pers[3:0]) begin
                                next_st.status[`RGBP_ST_CINT] = 1'b1;
                            end
                        end
                    end
                end
            end
            rgbp_pkg::ST_WAIT: begin
                if (!st.enable[`RGBP_EN_WAIT]) begin
                    next_st.fsm = rgbp_pkg::ST_PROX;
                end else begin
                    next_st.stepc = st.stepc + 20'h00001;
                    if (st.stepc == STEP_LAST) begin
                        next_st.stepc = 20'h00000;
                        next_st.sub   = st.sub + 4'h1;
                        if (st.sub == (st.cfg[`RGBP_CFG_WLONG] ? `RGBP_WAIT_LONG_MUL - 4'h1 : 4'h0)) begin
                            next_st.sub   = 4'h0;
                            next_st.nstep = st.nstep + 8'h01;
                            if (st.nstep == 8'hFF) begin
                                next_st.fsm = rgbp_pkg::ST_PROX;
                            end
                        end
                    end
                end
            end
        endcase
        if (!st.enable[`RGBP_EN_PON]) begin
            next_st.fsm = rgbp_pkg::ST_SLEEP;
        end
        if (next_st.fsm != st.fsm) begin
            next_st.stepc = 20'h00000;
            next_st.sub   = 4'h0;
            next_st.tick  = 8'h00;
            next_st.pcnt  = 8'h00;
            next_st.pacc  = 16'h0000;
            next_st.acc   = '0;
            next_st.nstep = next_st.fsm == rgbp_pkg::ST_COLOUR ? st.itime : st.wtime;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st        <= '0;
            st.fsm    <= rgbp_pkg::ST_SLEEP;
            st.i2s    <= rgbp_pkg::I2_IDLE;
            st.itime  <= `RGBP_RST_ITIME;
            st.wtime  <= `RGBP_RST_WTIME;
            st.col_hi <= `RGBP_RST_HI;
            st.prx_hi <= `RGBP_RST_HI;
            st.pulses <= `RGBP_RST_PULSES;
            st.scl_s  <= 3'h7;
            st.sda_s  <= 3'h7;
        end else begin
            st <= next_st;
        end
    end

    assign rdata           = st.rdata;
    assign sda_out         = 1'b0;
    assign sda_oe          = st.sda_oe;
    assign int_out         = 1'b0;
    assign int_oe          = |(st.status & st.mask);
    assign ir_led_sink_out = st.fsm == rgbp_pkg::ST_PROX && st.enable[`RGBP_EN_PRX] &&
                             st.pulses != 8'h00 && st.tick < ON_CYC;
    assign led_drive_sel   = st.drive;
    assign low_power       = st.fsm == rgbp_pkg::ST_SLEEP || st.fsm == rgbp_pkg::ST_WAIT;

    a_led_on_width: assert property (@(posedge clk) disable iff (srst)
        $rose(ir_led_sink_out) |-> ##62 ir_led_sink_out ##1 !ir_led_sink_out)
        else $error("LED on time wrong");
    a_led_period: assert property (@(posedge clk) disable iff (srst)
        $rose(ir_led_sink_out) && st.pcnt != st.pulses - 8'h01 && st.enable[`RGBP_EN_PON]
        && !wr_stb && st.i2s == rgbp_pkg::I2_IDLE |-> ##140 $rose(ir_led_sink_out))
        else $error("LED pulse period wrong");
    a_led_only_prox: assert property (@(posedge clk) disable iff (srst)
        ir_led_sink_out |-> st.fsm == rgbp_pkg::ST_PROX)
        else $error("LED on outside proximity");
    a_int_sticky: assert property (@(posedge clk) disable iff (srst)
        int_oe && !wr_stb && st.i2s == rgbp_pkg::I2_IDLE |=> int_oe)
        else $error("Interrupt dropped without a clear");
    a_data_buffered: assert property (@(posedge clk) disable iff (srst)
        st.cdata != $past(st.cdata) |-> $past(st.fsm) == rgbp_pkg::ST_COLOUR
        && st.fsm != rgbp_pkg::ST_COLOUR)
        else $error("Data changed mid cycle");
    a_col_limit: assert property (@(posedge clk) disable iff (srst)
        $rose(st.status[`RGBP_ST_CINT]) |-> st.cdata[0] < st.col_lo || st.cdata[0] > st.col_hi)
        else $error("Colour event inside limits");
    a_prx_limit: assert property (@(posedge clk) disable iff (srst)
        $rose(st.status[`RGBP_ST_PINT]) |-> st.pdata < st.prx_lo || st.pdata > st.prx_hi)
        else $error("Proximity event inside limits");
    a_col_persist: assert property (@(posedge clk) disable iff (srst)
        $rose(st.status[`RGBP_ST_CINT]) |-> st.pcol >= st.pers[3:0] && st.pcol != 4'h0)
        else $error("Colour event before persistence");
    a_rest_power: assert property (@(posedge clk) disable iff (srst)
        !st.enable[`RGBP_EN_PON] |=> low_power)
        else $error("Not resting while powered down");
    a_addr_match: assert property (@(posedge clk) disable iff (srst)
        st.i2s == rgbp_pkg::I2_ACK_A |-> st.sh[7:1] == I2C_ADDR && st.sda_oe)
        else $error("Acknowledged a foreign address");

endmodule // rgbp_top
`default_nettype wire

/* File: dv/rgbp_host.sv */
// Host-side I2C controller model that drives the sensor's clock and data pins.
`timescale 1ns/1ps
`default_nettype none
module rgbp_host (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        #100 sda_low = ~b;
        #300 scl = 1'b1;
        #390 r = sda;
        #10 scl = 1'b0;
    endtask
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Writes 16 bits at byte pointer p; ok drops if any byte is not acknowledged.
    task automatic write16(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                           output logic ok);
        logic k;
        #30 sda_low = 1'b1;
        #400 scl = 1'b0;
        byte_out({a, 1'b0}, ok);
        if (ok) begin
            byte_out(p, k);
            byte_out(d[7:0], ok);
            ok &= k;
            byte_out(d[15:8], k);
            ok &= k;
        end
        #100 sda_low = 1'b1;
        #300 scl = 1'b1;
        #400 sda_low = 1'b0;
        #400;
    endtask
    // Reads 16 bits at byte pointer p after a repeated start; the low byte comes first.
    task automatic read16(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d,
                          output logic ok);
        logic k;
        logic r;
        #30 sda_low = 1'b1;
        #400 scl = 1'b0;
        byte_out({a, 1'b0}, ok);
        byte_out(p, k);
        ok &= k;
        #100 sda_low = 1'b0;
        #300 scl = 1'b1;
        #400 sda_low = 1'b1;
        #400 scl = 1'b0;
        byte_out({a, 1'b1}, k);
        ok &= k;
        for (int i = 0; i < 16; i++) begin
            bit_io(1'b1, r);
            d[i < 8 ? 7 - i : 23 - i] = r;
            if (i == 7 || i == 15) begin
                bit_io(i == 15, r);
            end
        end
        #100 sda_low = 1'b1;
        #300 scl = 1'b1;
        #400 sda_low = 1'b0;
        #400;
    endtask
endmodule // rgbp_host
`default_nettype wire

/* File: dv/rgbp_top_tb.sv */
// Self-checking bench of the colour and proximity sensor control block.
`timescale 1ns/1ps
`default_nettype none
module rgbp_top_tb;
    localparam logic [6:0]  DEV = 7'h5A;
    localparam logic [4:0]  RA [5] = '{5'h01, 5'h02, 5'h07, 5'h09, 5'h1F};
    localparam logic [15:0] RE [5] = '{16'h00FF, 16'h00FF, 16'hFFFF, 16'h0001, 16'h0000};
    localparam logic [15:0] DE [5] = '{16'hFFFF, 16'h0100, 16'h0200, 16'h0300, 16'h000F};
    logic                 clk = 1'b0;
    logic                 srst = 1'b1;
    logic [4:0]           addr = 5'h00;
    logic [15:0]          wdata = 16'h0000;
    logic                 wr_stb = 1'b0;
    logic                 rd_stb = 1'b0;
    logic [15:0]          rdata, v;
    logic                 scl, host_low, sda_out, sda_oe, int_out, int_oe, led, low_power, ok;
    logic [1:0]           drv;
    int                   mismatches = 0, checked = 0, cyc = 0, last = -100000, rises = 0;
    int                   act = 0;
    rgbp_pkg::rgbp_samp_t chans = {10'h003, 10'h002, 10'h001, 10'h3FF};
    logic [9:0]           prox = 10'h005;
    wire logic            sda_line = (sda_oe ? sda_out : 1'b1) & ~host_low;
    wire logic            int_line = int_oe ? int_out : 1'b1;

    rgbp_top #(.STEP_CYC(20), .I2C_ADDR(DEV)) rgbp_top_i (
        .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .colour_channels(chans), .prox_sample(prox),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .int_out(int_out), .int_oe(int_oe), .ir_led_sink_out(led),
        .led_drive_sel(drv), .low_power(low_power));
    rgbp_host rgbp_host_i (.scl(scl), .sda_low(host_low), .sda(sda_line));

    always #50 clk = ~clk;
    always @(negedge clk) cyc++;
    always @(posedge led) begin
        rises++;
        if (cyc - last < 1000) chk(16'(cyc - last), 16'h008C);
        last = cyc;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic wait_status(input int b);
        logic [15:0] s;
        s = 16'h0000;
        for (int n = 0; n < 8000 && s[b] !== 1'b1; n++) rd(5'h0B, s);
        chk({15'h0000, s[b]}, 16'h0001);
    endtask
    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        complete_run;
    end

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        chk({15'h0000, low_power}, 16'h0001);
        chk({15'h0000, int_line}, 16'h0001);
        for (int i = 0; i < 5; i++) begin
            rd(RA[i], v);
            chk(v, RE[i]);
        end
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            wr(5'h0A, 16'(i));
            @(negedge clk);
            chk({14'h0000, drv}, 16'(i));
        end
        $display("drive test done");
        wr(5'h01, 16'h0000);
        wr(5'h09, 16'h0003);
        wr(5'h05, 16'h1000);
        wr(5'h06, 16'h0010);
        wr(5'h08, 16'h0020);
        wr(5'h00, 16'h0007);
        repeat (2) @(negedge clk);
        chk({15'h0000, low_power}, 16'h0000);
        wait_status(1);
        chk(16'(rises), 16'h0003);
        wait_status(0);
        rd(5'h0B, v);
        chk(v, 16'h0013);
        chk({15'h0000, int_line}, 16'h0001);
        for (int i = 0; i < 5; i++) begin
            rd(5'h10 + 5'(i), v);
            chk(v, DE[i]);
        end
        $display("measurement test done");
        rgbp_host_i.write16(7'h11, 8'h18, 16'h0030, ok);
        chk({15'h0000, ok}, 16'h0000);
        rgbp_host_i.write16(DEV, 8'h18, 16'h0030, ok);
        chk({15'h0000, ok}, 16'h0001);
        @(negedge clk);
        chk({15'h0000, int_line}, 16'h0000);
        rgbp_host_i.read16(DEV, 8'h0A, v, ok);
        chk(v, 16'h1000);
        chk({15'h0000, ok}, 16'h0001);
        wr(5'h0B, 16'h0013);
        wait_status(1);
        rd(5'h0B, v);
        chk(v, 16'h0033);
        wr(5'h00, 16'h0000);
        rgbp_host_i.write16(DEV, 8'h16, 16'h00FF, ok);
        rd(5'h0B, v);
        chk(v, 16'h0000);
        chk({15'h0000, int_line}, 16'h0001);
        chk({15'h0000, low_power}, 16'h0001);
        $display("interrupt test done");
        wr(5'h03, 16'h0001);
        wr(5'h00, 16'h0009);
        repeat (4) @(negedge clk);
        repeat (484) begin
            @(negedge clk);
            if (!low_power) act++;
        end
        chk(16'(act), 16'h0004);
        $display("wait test done");
        complete_run;
    end
endmodule // rgbp_top_tb
`default_nettype wire
